// ### rtl/cmd_power_control.sv
`timescale 1ns/10ps
`default_nettype none
`include "cmd_power_defs.svh"

// How it works
// - decode command from strobes at rising edge
// - bank address picks bank or mode register
// - termination never steers states; off in self refresh
// - self refresh exit seen at self_refresh without running clock, at refresh_running only on clock edges
// - clock enable edges enter and leave power down
// - clock enable rise leaves self refresh
// - self refresh only from idle via refresh
// - banks open gives active power down, else precharge
// - mask bit high inhibits write of its byte lane
// - chip select high runs no new command
// - no-operation registers nothing new
// - activate opens row until bank precharged
// - wide variant ignores top row bit
// - self refresh switches delay-locked loop off
module cmd_power_control
  import cmd_power_pkg::*;
#(
  parameter bit WIDE_VARIANT = 1'b0
)(
  input  wire logic                         clock,
  input  wire logic                         reset_n,
  input  wire logic                         cke_pin,
  input  wire logic                         cs_n_pin,
  input  wire logic                         ras_n_pin,
  input  wire logic                         cas_n_pin,
  input  wire logic                         we_n_pin,
  input  wire logic [`BANK_ADDR_WIDTH-1:0]  bank_addr_pin,
  input  wire logic [`ROW_ADDR_WIDTH-1:0]   addr_pin,
  input  wire logic                         odt_pin,
  input  wire logic                         wr_valid,
  output logic                              wr_ready,
  input  wire logic [`DATA_WIDTH-1:0]       wr_data,
  input  wire logic [`MASK_WIDTH-1:0]       wr_mask,
  output logic                              array_wr_valid,
  input  wire logic                         array_wr_ready,
  output logic [`DATA_WIDTH-1:0]            array_wr_data,
  output logic [`MASK_WIDTH-1:0]            array_wr_enable,
  output logic [3:0]                        op_code,
  output logic                              op_valid,
  output logic [`BANK_ADDR_WIDTH-1:0]       op_bank,
  output logic [`ROW_ADDR_WIDTH-1:0]        op_row,
  output logic [`BANK_COUNT-1:0]            bank_open,
  output logic                              power_down,
  output logic                              active_power_down,
  output logic                              self_refresh,
  output logic                              dll_enable,
  output logic                              odt_active,
  output logic                              read_allowed,
  output logic                              refresh_running
);
  typedef struct packed {
    logic                          cke_s1;
    logic                          cke_s2;
    logic                          cke_prev;
    logic [3:0]                    cmd_s1;
    logic [3:0]                    cmd_s2;
    logic [`BANK_ADDR_WIDTH-1:0]   ba_s1;
    logic [`BANK_ADDR_WIDTH-1:0]   ba_s2;
    logic [`ROW_ADDR_WIDTH-1:0]    addr_s1;
    logic [`ROW_ADDR_WIDTH-1:0]    addr_s2;
    power_state_e                  state;
    logic [`BANK_COUNT-1:0]        open;
    logic [`BANK_COUNT-1:0][`ROW_ADDR_WIDTH-1:0] rows;
    op_e                           op;
    logic                          op_v;
    logic [`BANK_ADDR_WIDTH-1:0]   bank;
    logic [`ROW_ADDR_WIDTH-1:0]    row;
    logic [`SR_EXIT_READ_W-1:0]    read_wait;
    logic                          odt_en;
    logic [`ROW_ADDR_WIDTH-1:0]    emr1;
  } ctl_s;

  ctl_s ctl_reg;
  ctl_s ctl_next;

  logic                      cmd_sel;
  logic [2:0]                strobes;
  cmd_class_e                cmd_class;
  logic                      cke_now;
  logic                      sr_wake;
  logic [`MASK_WIDTH-1:0]    keep_in;
  logic [`BANK_ADDR_WIDTH-1:0] bank_in;
  logic                      self_refresh_state;

  // the self refresh wake path bypasses the synchroniser so self_refresh still drops with a stopped clock
  // asynchronous exit
  assign sr_wake = (ctl_reg.state == PS_SELF_REF) && cke_pin;
  assign cke_now = ctl_reg.cke_s2;
  // command pins ride the same two flops as clock enable, so each command stays
  // paired with the enable level registered on the same edge
  assign cmd_sel = !ctl_reg.cmd_s2[3];
  assign strobes = ctl_reg.cmd_s2[2:0];
  assign bank_in = ctl_reg.ba_s2;

  always_comb begin
    if (!cmd_sel) begin
      cmd_class = CMD_DESELECT;
    end else if (strobes == 3'h7) begin
      cmd_class = CMD_NOP;
    end else if (strobes == 3'h1) begin
      cmd_class = CMD_REFRESH;
    end else if (strobes == 3'h0) begin
      cmd_class = CMD_MODE_SET;
    end else begin
      cmd_class = CMD_OTHER;
    end
  end

  assign keep_in = ~wr_mask;

  always_comb begin
    logic [`ROW_ADDR_WIDTH-1:0] row_in;
    row_in   = ctl_reg.addr_s2;
    ctl_next = ctl_reg;
    ctl_next.cke_s1   = cke_pin;
    ctl_next.cke_s2   = ctl_reg.cke_s1;
    ctl_next.cke_prev = cke_now;
    ctl_next.cmd_s1   = {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin};
    ctl_next.cmd_s2   = ctl_reg.cmd_s1;
    ctl_next.ba_s1    = bank_addr_pin;
    ctl_next.ba_s2    = ctl_reg.ba_s1;
    ctl_next.addr_s1  = addr_pin;
    ctl_next.addr_s2  = ctl_reg.addr_s1;
    ctl_next.op_v     = 1'b0;
    ctl_next.op       = OP_NOP;
    if (WIDE_VARIANT) begin
      row_in[`ROW_TOP_BIT] = 1'b0;
    end
    if (ctl_reg.read_wait != '0) begin
      ctl_next.read_wait = ctl_reg.read_wait - 1'b1;
    end
    unique case (ctl_reg.state)
      PS_IDLE, PS_ACTIVE: begin
        if (ctl_reg.cke_prev && !cke_now) begin
          if (cmd_class == CMD_REFRESH && ctl_reg.open == '0) begin
            ctl_next.state = PS_SELF_REF;
            ctl_next.op    = OP_SRE;
            ctl_next.op_v  = 1'b1;
          end else begin
            ctl_next.state = PS_PRE_PD;
          end
        end else if (ctl_reg.cke_prev && cke_now) begin
          if (cmd_class == CMD_OTHER || cmd_class == CMD_REFRESH ||
              cmd_class == CMD_MODE_SET) begin
            ctl_next.op_v = 1'b1;
            ctl_next.bank = bank_in;
            ctl_next.row  = row_in;
            unique case (strobes)
              3'h3: begin
                ctl_next.op = OP_ACT;
                ctl_next.open[bank_in] = 1'b1;
                ctl_next.rows[bank_in] = row_in;
              end
              3'h2: begin
                if (ctl_reg.addr_s2[10]) begin
                  ctl_next.op   = OP_PREALL;
                  ctl_next.open = '0;
                end else begin
                  ctl_next.op = OP_PRE;
                  ctl_next.open[bank_in] = 1'b0;
                end
              end
              3'h5: ctl_next.op = (ctl_reg.read_wait == '0) ? OP_READ : OP_NOP;
              3'h4: ctl_next.op = OP_WRITE;
              3'h1: ctl_next.op = OP_REF;
              3'h0: begin
                ctl_next.op = OP_MRS;
                if (bank_in == `EMR1_SELECT) begin
                  ctl_next.emr1 = ctl_reg.addr_s2;
                end
              end
              default: ctl_next.op = OP_NOP;
            endcase
          end
        end
      end
      PS_PRE_PD: begin
        if (!ctl_reg.cke_prev && cke_now) begin
          ctl_next.state = PS_IDLE;
        end
      end
      PS_SELF_REF: begin
        if (cke_now) begin
          ctl_next.state     = PS_IDLE;
          ctl_next.read_wait = `SR_EXIT_READ_W'(`SR_EXIT_READ_CLOCKS);
        end
      end
      default: ctl_next.state = PS_IDLE;
    endcase
    if (ctl_next.state != PS_SELF_REF && ctl_next.state != PS_PRE_PD) begin
      ctl_next.state = (ctl_next.open != '0) ? PS_ACTIVE : PS_IDLE;
    end
    ctl_next.odt_en = ctl_next.emr1[`EMR1_ODT_BIT_LO] || ctl_next.emr1[`EMR1_ODT_BIT_HI];
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctl_reg       <= '0;
      ctl_reg.state <= PS_IDLE;
      ctl_reg.cmd_s1 <= 4'hF;
      ctl_reg.cmd_s2 <= 4'hF;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  write_buffer u_write_buffer (
    .clock     (clock),
    .reset_n   (reset_n),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .in_keep   (keep_in),
    .out_valid (array_wr_valid),
    .out_ready (array_wr_ready),
    .out_data  (array_wr_data),
    .out_keep  (array_wr_enable)
  );

  assign op_code           = ctl_reg.op;
  assign op_valid          = ctl_reg.op_v;
  assign op_bank           = ctl_reg.bank;
  assign op_row            = ctl_reg.row;
  assign bank_open         = ctl_reg.open;
  assign power_down        = (ctl_reg.state == PS_PRE_PD);
  assign active_power_down = power_down && (ctl_reg.open != '0);
  assign self_refresh      = (ctl_reg.state == PS_SELF_REF) && !sr_wake;
  assign dll_enable        = (ctl_reg.state != PS_SELF_REF);
  assign odt_active        = ctl_reg.odt_en && odt_pin && (ctl_reg.state != PS_SELF_REF);
  assign read_allowed      = (ctl_reg.read_wait == '0);
  assign refresh_running   = (ctl_reg.state == PS_SELF_REF);
  assign self_refresh_state = (ctl_reg.state == PS_SELF_REF);

  sequence fall_s;
    ctl_reg.cke_prev && !cke_now;
  endsequence
  sequence sr_exit_s;
    ctl_reg.state == PS_SELF_REF && cke_now;
  endsequence

  pd_entry_a: assert property (@(posedge clock) disable iff (!reset_n)
    fall_s and (ctl_reg.state inside {PS_IDLE, PS_ACTIVE}) && cmd_class != CMD_REFRESH
      |=> power_down) else $error("no power down after enable fall");
  sr_entry_a: assert property (@(posedge clock) disable iff (!reset_n)
    fall_s and (ctl_reg.state == PS_IDLE) && cmd_class == CMD_REFRESH
      |=> self_refresh_state) else $error("no self refresh entry");
  sr_exit_wait_a: assert property (@(posedge clock) disable iff (!reset_n)
    sr_exit_s |=> !read_allowed [*8]) else $error("read allowed too soon");
  sr_wait_end_a: assert property (@(posedge clock) disable iff (!reset_n)
    sr_exit_s |-> ##201 read_allowed) else $error("read holdoff too long");
  apd_kind_a: assert property (@(posedge clock) disable iff (!reset_n)
    power_down |-> (active_power_down == (bank_open != '0)))
    else $error("power down kind wrong");
  deselect_idle_a: assert property (@(posedge clock) disable iff (!reset_n)
    ctl_reg.cmd_s2[3] && ctl_reg.cke_prev && cke_now |=> !op_valid)
    else $error("deselect started a command");
  nop_idle_a: assert property (@(posedge clock) disable iff (!reset_n)
    cmd_class == CMD_NOP |=> $stable(bank_open)) else $error("nop changed banks");
  dll_off_a: assert property (@(posedge clock) disable iff (!reset_n)
    ctl_reg.state == PS_SELF_REF |-> !dll_enable) else $error("loop on in self refresh");
  odt_off_a: assert property (@(posedge clock) disable iff (!reset_n)
    ctl_reg.state == PS_SELF_REF |-> !odt_active) else $error("termination in self refresh");
endmodule // cmd_power_control

`default_nettype wire

// ### rtl/cmd_power_defs.svh
`ifndef CMD_POWER_DEFS_SVH
`define CMD_POWER_DEFS_SVH

`define BANK_COUNT        8
`define BANK_ADDR_WIDTH   3
`define ROW_ADDR_WIDTH    15
`define ROW_TOP_BIT       14
`define DATA_WIDTH        16
`define MASK_WIDTH        2
`define BURST_LENGTH_FOUR 3'h4
`define BURST_BEATS_W     3
`define CLOCK_PERIOD_NS   20
`define CKE_MIN_HOLD      2'h3
`define SR_EXIT_READ_CLOCKS 200
`define SR_EXIT_READ_W    8
`define MODE_SET_CYCLES   2
`define MODE_SET_W        2
`define EMR1_ODT_BIT_LO   2
`define EMR1_ODT_BIT_HI   6
`define EMR1_SELECT       3'h1

`endif

// ### rtl/cmd_power_pkg.sv
package cmd_power_pkg;
  typedef enum logic [4:0] {
    CMD_DESELECT = 5'h01,
    CMD_NOP      = 5'h02,
    CMD_OTHER    = 5'h04,
    CMD_REFRESH  = 5'h08,
    CMD_MODE_SET = 5'h10
  } cmd_class_e;

  typedef enum logic [3:0] {
    PS_IDLE     = 4'h1,
    PS_ACTIVE   = 4'h2,
    PS_PRE_PD   = 4'h4,
    PS_SELF_REF = 4'h8
  } power_state_e;

  typedef enum logic [3:0] {
    OP_NOP    = 4'h0,
    OP_ACT    = 4'h1,
    OP_READ   = 4'h2,
    OP_WRITE  = 4'h3,
    OP_PRE    = 4'h4,
    OP_PREALL = 4'h5,
    OP_REF    = 4'h6,
    OP_MRS    = 4'h7,
    OP_SRE    = 4'h8
  } op_e;
endpackage

// ### rtl/write_buffer.sv
`timescale 1ns/10ps
`default_nettype none
`include "cmd_power_defs.svh"

// two-entry skid buffer: a stall on the drain side never drops a word
module write_buffer
  import cmd_power_pkg::*;
(
  input  wire logic                        clock,
  input  wire logic                        reset_n,
  input  wire logic                        in_valid,
  output logic                             in_ready,
  input  wire logic [`DATA_WIDTH-1:0]      in_data,
  input  wire logic [`MASK_WIDTH-1:0]      in_keep,
  output logic                             out_valid,
  input  wire logic                        out_ready,
  output logic [`DATA_WIDTH-1:0]           out_data,
  output logic [`MASK_WIDTH-1:0]           out_keep
);
  typedef struct packed {
    logic [1:0][`DATA_WIDTH-1:0] data;
    logic [1:0][`MASK_WIDTH-1:0] keep;
    logic                        rd_ptr;
    logic                        wr_ptr;
    logic [1:0]                  count;
  } buf_s;

  buf_s buf_reg;
  buf_s buf_next;
  logic push;
  logic pop;

  assign in_ready  = (buf_reg.count != 2'h2);
  assign out_valid = (buf_reg.count != 2'h0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = buf_reg.data[buf_reg.rd_ptr];
  assign out_keep  = buf_reg.keep[buf_reg.rd_ptr];

  always_comb begin
    buf_next = buf_reg;
    if (push) begin
      buf_next.data[buf_reg.wr_ptr] = in_data;
      buf_next.keep[buf_reg.wr_ptr] = in_keep;
      buf_next.wr_ptr = ~buf_reg.wr_ptr;
    end
    if (pop) begin
      buf_next.rd_ptr = ~buf_reg.rd_ptr;
    end
    buf_next.count = buf_reg.count + {1'h0, push} - {1'h0, pop};
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      buf_reg <= '0;
    end else begin
      buf_reg <= buf_next;
    end
  end

  count_bound_a: assert property (@(posedge clock) disable iff (!reset_n)
    buf_reg.count <= 2'h2) else $error("buffer count above two");
  hold_on_stall_a: assert property (@(posedge clock) disable iff (!reset_n)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("buffered word changed while stalled");
endmodule // write_buffer

`default_nettype wire

// ### tb/ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "cmd_power_defs.svh"

// memory controller stand-in driving the command pins
module ctrl_model (
  input  wire logic                       clock,
  output logic                            cke,
  output logic                            cs_n,
  output logic [2:0]                      rcw_n,
  output logic [`BANK_ADDR_WIDTH-1:0]     ba,
  output logic [`ROW_ADDR_WIDTH-1:0]      a
);
  initial begin
    cke = 1'b1;
    cs_n = 1'b1;
    rcw_n = 3'h7;
    ba = 3'h0;
    a = 15'h0000;
  end

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clock);
      #1;
      cs_n = 1'b0;
      rcw_n = 3'h7;
      a = ~a;
    end
  endtask

  // unselected strobe and address lines do not keep old values; bank address does
  task automatic desel();
    @(posedge clock);
    #1;
    cs_n = 1'b1;
    rcw_n = ~rcw_n;
    a = ~a;
  endtask

  task automatic send(input logic [2:0] c, input logic [2:0] b,
                      input logic [14:0] r, input logic k);
    logic moved;
    begin
      // only legal commands, enable high outside power states
      @(posedge clock);
      #1;
      moved = (k !== cke);
      cke = k;
      cs_n = 1'b0;
      rcw_n = c;
      ba = b;
      a = r;
      // new clock enable held three edges
      idle(moved ? 3 : 1);
    end
  endtask
endmodule // ctrl_model

`default_nettype wire

// ### tb/ddr2_command_power_state_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "cmd_power_defs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module ddr2_command_power_state_control_tb
  import cmd_power_pkg::*;
;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        odt = 1'b0;
  logic        wr_valid = 1'b0;
  logic [15:0] wr_data = 16'h0000;
  logic [1:0]  wr_mask = 2'h0;
  logic        aw_ready = 1'b1;
  logic        wr_ready, aw_valid, op_valid, pd, apd, sr, dll, odt_act, rd_ok;
  logic [15:0] aw_data;
  logic [1:0]  aw_en;
  logic [3:0]  op_code, last_op;
  logic [2:0]  op_bank, last_bank, ba, rcw;
  logic [14:0] op_row, last_row, a;
  logic [7:0]  bank_open;
  logic        cke, cs_n, ref_run;
  int          err_count = 0;
  int          checks_done = 0;
  int          op_seen = 0;
  int          cycles = 0;

  always #10 clock = ~clock;

  ctrl_model ctrl (.clock(clock), .cke(cke), .cs_n(cs_n), .rcw_n(rcw), .ba(ba), .a(a));

  cmd_power_control #(.WIDE_VARIANT(1'b1)) DUT (
    .clock(clock), .reset_n(reset_n), .cke_pin(cke), .cs_n_pin(cs_n),
    .ras_n_pin(rcw[2]), .cas_n_pin(rcw[1]), .we_n_pin(rcw[0]),
    .bank_addr_pin(ba), .addr_pin(a), .odt_pin(odt),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .wr_mask(wr_mask),
    .array_wr_valid(aw_valid), .array_wr_ready(aw_ready),
    .array_wr_data(aw_data), .array_wr_enable(aw_en),
    .op_code(op_code), .op_valid(op_valid), .op_bank(op_bank), .op_row(op_row),
    .bank_open(bank_open), .power_down(pd), .active_power_down(apd),
    .self_refresh(sr), .dll_enable(dll), .odt_active(odt_act),
    .read_allowed(rd_ok), .refresh_running(ref_run));

  always @(posedge clock) begin
    if (op_valid === 1'b1) begin
      op_seen <= op_seen + 1;
      last_op <= op_code;
      last_bank <= op_bank;
      last_row <= op_row;
    end
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic do_op(input logic [2:0] c, input logic [2:0] b, input logic [14:0] r,
                       input logic k, input logic [3:0] eo, input logic [14:0] er);
    int n0;
    begin
      n0 = op_seen;
      ctrl.send(c, b, r, k);
      ctrl.idle(3);
      `CHK(op_seen - n0, 1)
      `CHK(last_op, eo)
      if (eo == OP_ACT || eo == OP_MRS)
        `CHK(last_bank, b)
      if (eo == OP_ACT)
        `CHK(last_row, er)
    end
  endtask

  task automatic t_cmds();
    int n0;
    begin
      n0 = op_seen;
      ctrl.desel();
      ctrl.desel();
      ctrl.idle(4);
      `CHK(op_seen - n0, 0)
      do_op(3'h0, 3'h1, 15'h0044, 1'b1, OP_MRS, 15'h0);
      ctrl.idle(`MODE_SET_CYCLES);
      odt = 1'b1;
      ctrl.idle(2);
      `CHK(odt_act, 1'b1)
      do_op(3'h1, 3'h0, 15'h0, 1'b1, OP_REF, 15'h0);
      do_op(3'h3, 3'h5, 15'h7ABC, 1'b1, OP_ACT, 15'h3ABC);
      `CHK(bank_open, 8'h20)
      do_op(3'h4, 3'h5, 15'h0010, 1'b1, OP_WRITE, 15'h0);
      ctrl.idle(4);
      do_op(3'h5, 3'h5, 15'h0010, 1'b1, OP_READ, 15'h0);
      ctrl.idle(4);
      do_op(3'h2, 3'h5, 15'h0000, 1'b1, OP_PRE, 15'h0);
      `CHK(bank_open, 8'h00)
      do_op(3'h3, 3'h5, 15'h0123, 1'b1, OP_ACT, 15'h0123);
      do_op(3'h3, 3'h2, 15'h4001, 1'b1, OP_ACT, 15'h0001);
      `CHK(bank_open, 8'h24)
      $display("test commands done");
    end
  endtask

  task automatic t_power_down();
    begin
      ctrl.send(3'h7, 3'h0, 15'h0, 1'b0);
      ctrl.idle(3);
      `CHK({pd, apd}, 2'b11)
      `CHK(bank_open, 8'h24)
      `CHK(ref_run, 1'b0)
      ctrl.send(3'h7, 3'h0, 15'h0, 1'b1);
      ctrl.idle(3);
      `CHK(pd, 1'b0)
      do_op(3'h2, 3'h0, 15'h0400, 1'b1, OP_PREALL, 15'h0);
      `CHK(bank_open, 8'h00)
      // precharge has finished before enable falls
      ctrl.send(3'h7, 3'h0, 15'h0, 1'b0);
      ctrl.idle(6);
      `CHK({pd, apd, sr}, 3'b100)
      ctrl.send(3'h7, 3'h0, 15'h0, 1'b1);
      ctrl.idle(3);
      `CHK(pd, 1'b0)
      $display("test power down done");
    end
  endtask

  task automatic t_self_refresh();
    int cnt;
    begin
      do_op(3'h1, 3'h0, 15'h0, 1'b0, OP_SRE, 15'h0);
      ctrl.idle(10);
      `CHK({sr, dll, odt_act}, 3'b100)
      `CHK(ref_run, 1'b1)
      ctrl.send(3'h7, 3'h0, 15'h0, 1'b1);
      `CHK({sr, dll, rd_ok}, 3'b010)
      cnt = 0;
      while (rd_ok !== 1'b1 && cnt < 400) begin
        ctrl.idle(1);
        cnt++;
      end
      `CHK((cnt >= `SR_EXIT_READ_CLOCKS - 8) && (cnt <= `SR_EXIT_READ_CLOCKS + 2), 1'b1)
      `CHK(odt_act, 1'b1)
      do_op(3'h3, 3'h2, 15'h0007, 1'b1, OP_ACT, 15'h0007);
      do_op(3'h5, 3'h2, 15'h0008, 1'b1, OP_READ, 15'h0);
      $display("test self refresh done");
    end
  endtask

  task automatic t_wbuf();
    aw_ready = 1'b0;
    fork
      for (int i = 0; i < 4; i++) begin
        wr_valid = 1'b1;
        wr_data = 16'hA500 + 16'(i);
        wr_mask = 2'(i);
        while (wr_ready !== 1'b1) @(posedge clock) #1;
        @(posedge clock) #1;
        wr_valid = 1'b0;
      end
      begin
        repeat (8) @(posedge clock);
        #1;
        `CHK(wr_ready, 1'b0)
        aw_ready = 1'b1;
        for (int i = 0; i < 4; i++) begin
          while (aw_valid !== 1'b1) @(posedge clock) #1;
          `CHK(aw_data, 16'hA500 + 16'(i))
          `CHK(aw_en, ~2'(i))
          @(posedge clock) #1;
        end
      end
    join
    wr_valid = 1'b0;
    $display("test write buffer done");
  endtask

  initial begin
    repeat (12) @(posedge clock);
    #1;
    reset_n = 1'b1;
    ctrl.idle(4);
    `CHK({dll, rd_ok, bank_open}, 10'h300)
    t_cmds();
    t_power_down();
    t_self_refresh();
    t_wbuf();
    wrap_up();
  end
endmodule // ddr2_command_power_state_control_tb

`default_nettype wire
